/* File: design/pps_pkg.sv */
// shared constants, field layout and types of the pulse program sequencer
package pps_pkg;

    // program memory geometry
    localparam int unsigned AW = 10;
    localparam int unsigned DEPTH = 1024;
    localparam int unsigned WORD_W = 80;

    // instruction word fields, most significant first: pattern, data, opcode, delay
    localparam int unsigned PAT_W = 24;
    localparam int unsigned DATA_W = 20;
    localparam int unsigned OP_W = 4;
    localparam int unsigned DLY_W = 32;
    localparam int unsigned DLY_LSB = 0;
    localparam int unsigned OP_LSB = 32;
    localparam int unsigned DATA_LSB = 36;
    localparam int unsigned PAT_LSB = 56;

    // duration counter must hold delay times multiplier
    localparam int unsigned CNT_W = 52;

    // operation codes
    localparam logic [3:0] OP_CONTINUE = 4'h0;
    localparam logic [3:0] OP_STOP = 4'h1;
    localparam logic [3:0] OP_LOOP = 4'h2;
    localparam logic [3:0] OP_END_LOOP = 4'h3;
    localparam logic [3:0] OP_SUBROUTINE_CALL = 4'h4;
    localparam logic [3:0] OP_RETURN = 4'h5;
    localparam logic [3:0] OP_JUMP = 4'h6;
    localparam logic [3:0] OP_LONG_DELAY = 4'h7;
    localparam logic [3:0] OP_WAIT = 4'h8;

    // fixed exit latency added to a wait after the trigger, in clock cycles
    localparam logic [51:0] WAIT_EXTRA_CYC = 52'h0000000000006;
    localparam logic [51:0] CNT_ONE = 52'h0000000000001;
    localparam logic [19:0] LOOP_LAST_PASS = 20'h00001;
    localparam logic [19:0] LOOP_DEC = 20'h00001;
    localparam logic [9:0] PROG_START_ADDR = 10'h000;
    localparam logic [9:0] ADDR_STEP = 10'h001;

    // loop counter and return address storage
    localparam int unsigned STK_DEPTH = 4;
    localparam int unsigned SP_W = 2;
    localparam logic [1:0] SP_STEP = 2'h1;

    // register map, byte addresses on the apb bus
    localparam int unsigned RA_W = 12;
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_PROG_ADDR = 12'h008;
    localparam logic [11:0] REG_PROG_DELAY = 12'h00c;
    localparam logic [11:0] REG_PROG_CTRL = 12'h010;
    localparam logic [11:0] REG_PROG_PATTERN = 12'h014;

    // register fields
    localparam int unsigned CTRL_START_BIT = 0;
    localparam int unsigned CTRL_HALT_BIT = 1;
    localparam int unsigned ST_RUN_BIT = 0;
    localparam int unsigned ST_STOP_BIT = 1;
    localparam int unsigned ST_WAIT_BIT = 2;
    localparam int unsigned ST_PC_LSB = 16;
    localparam int unsigned PCTRL_OP_LSB = 0;
    localparam int unsigned PCTRL_DATA_LSB = 4;

    typedef enum logic [2:0] {
        PPS_IDLE,
        PPS_PRIME,
        PPS_EXEC,
        PPS_WAIT,
        PPS_STOPPED
    } pps_state_e;

endpackage : pps_pkg

/* File: design/pps_prog_mem.sv */
// single port program memory with registered read data
`timescale 1ns/1ps
module pps_prog_mem (
    input wire logic pclk, // clock
    input wire logic we, // write strobe
    input wire logic re, // read strobe
    input wire logic [pps_pkg::AW-1:0] addr, // word address
    input wire logic [pps_pkg::WORD_W-1:0] wdata, // word to store
    output logic [pps_pkg::WORD_W-1:0] rdata // word read, held until next read
);
    logic [pps_pkg::WORD_W-1:0] mem [pps_pkg::DEPTH];

    // no reset on the array; read data hold lets the sequencer prefetch early
    always_ff @(posedge pclk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        if (re) begin
            rdata <= mem[addr];
        end
    end
endmodule : pps_prog_mem

/* File: design/pps_sequencer.sv */
// pulse program sequencer: apb program loader, instruction decoder and timer
`timescale 1ns/1ps
module pps_sequencer (
    input wire logic pclk, // 50 MHz master clock
    input wire logic presetn, // asynchronous reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction, high for write
    input wire logic [pps_pkg::RA_W-1:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error, unmapped address
    input wire logic trig_n, // hardware trigger, active low
    output logic [pps_pkg::PAT_W-1:0] out_pattern, // 24 output bits
    output logic running, // program executing
    output logic stopped, // program halted
    output logic waiting // waiting for trigger
);
    pps_pkg::pps_state_e state_q;
    logic [pps_pkg::CNT_W-1:0] cnt_q;
    logic [pps_pkg::AW-1:0] rd_addr_q;
    logic [pps_pkg::AW-1:0] pc_q;
    logic [pps_pkg::DLY_W-1:0] dly_q;
    logic [pps_pkg::AW-1:0] prog_addr_q;
    logic [pps_pkg::DLY_W-1:0] prog_dly_q;
    logic [pps_pkg::OP_W-1:0] prog_op_q;
    logic [pps_pkg::DATA_W-1:0] prog_data_q;
    logic [pps_pkg::DATA_W-1:0] loop_cnt_q [pps_pkg::STK_DEPTH];
    logic [pps_pkg::AW-1:0] ret_addr_q [pps_pkg::STK_DEPTH];
    logic [pps_pkg::SP_W-1:0] lsp_q;
    logic [pps_pkg::SP_W-1:0] csp_q;
    logic [pps_pkg::WORD_W-1:0] mem_rdata;
    logic [pps_pkg::WORD_W-1:0] mem_wdata;
    logic [pps_pkg::AW-1:0] mem_addr;
    logic mem_we;
    logic mem_re;
    logic busy;
    logic adv;
    logic wr_fire;
    logic start_req;
    logic halt_req;
    logic commit;
    logic [pps_pkg::OP_W-1:0] w_op;
    logic [pps_pkg::DATA_W-1:0] w_data;
    logic [pps_pkg::DLY_W-1:0] w_dly;
    logic [pps_pkg::PAT_W-1:0] w_pat;
    logic [pps_pkg::AW-1:0] seq_addr;
    logic [pps_pkg::AW-1:0] nxt_addr;
    logic [pps_pkg::DATA_W-1:0] loop_top;
    logic [31:0] rd_val;

    // true when the address names a mapped register
    function automatic logic reg_hit(input logic [pps_pkg::RA_W-1:0] a);
        reg_hit = (a == pps_pkg::REG_CTRL) || (a == pps_pkg::REG_STATUS) ||
                  (a == pps_pkg::REG_PROG_ADDR) || (a == pps_pkg::REG_PROG_DELAY) ||
                  (a == pps_pkg::REG_PROG_CTRL) || (a == pps_pkg::REG_PROG_PATTERN);
    endfunction : reg_hit

    // opcodes 9 to 15 are folded onto continue so one decoder covers all codes
    function automatic logic [pps_pkg::OP_W-1:0] op_fold(input logic [pps_pkg::OP_W-1:0] op);
        op_fold = (op > pps_pkg::OP_WAIT) ? pps_pkg::OP_CONTINUE : op;
    endfunction : op_fold

    // cycles an instruction lasts, minus one, as loaded into the down counter
    function automatic logic [pps_pkg::CNT_W-1:0] dur_m1(
        input logic [pps_pkg::OP_W-1:0] op,
        input logic [pps_pkg::DLY_W-1:0] dly,
        input logic [pps_pkg::DATA_W-1:0] mult
    );
        logic [pps_pkg::CNT_W-1:0] d;
        d = {{(pps_pkg::CNT_W-pps_pkg::DLY_W){1'b0}}, dly};
        if (op == pps_pkg::OP_LONG_DELAY) begin
            d = d * {{(pps_pkg::CNT_W-pps_pkg::DATA_W){1'b0}}, mult};
        end
        dur_m1 = d - pps_pkg::CNT_ONE;
    endfunction : dur_m1

    // split the prefetched word into its fields
    assign w_dly = mem_rdata[pps_pkg::DLY_LSB +: pps_pkg::DLY_W];
    assign w_op = op_fold(mem_rdata[pps_pkg::OP_LSB +: pps_pkg::OP_W]);
    assign w_data = mem_rdata[pps_pkg::DATA_LSB +: pps_pkg::DATA_W];
    assign w_pat = mem_rdata[pps_pkg::PAT_LSB +: pps_pkg::PAT_W];

    // apb handshake qualifiers; writes land only at the edge with pready high
    assign wr_fire = psel && penable && pready && pwrite && reg_hit(paddr);
    assign start_req = wr_fire && (paddr == pps_pkg::REG_CTRL) && pwdata[pps_pkg::CTRL_START_BIT];
    assign halt_req = wr_fire && (paddr == pps_pkg::REG_CTRL) && pwdata[pps_pkg::CTRL_HALT_BIT];
    assign busy = (state_q == pps_pkg::PPS_PRIME) || (state_q == pps_pkg::PPS_EXEC) ||
                  (state_q == pps_pkg::PPS_WAIT);
    // loading is refused while running, so the sequencer owns the memory port then
    assign commit = wr_fire && (paddr == pps_pkg::REG_PROG_PATTERN) && !busy;

    // an instruction begins after priming or when the running count expires
    assign adv = !halt_req && ((state_q == pps_pkg::PPS_PRIME) ||
                 ((state_q == pps_pkg::PPS_EXEC) && (cnt_q == '0)));
    assign loop_top = loop_cnt_q[lsp_q - pps_pkg::SP_STEP];

    // next fetch address chosen from the instruction now beginning
    always_comb begin
        nxt_addr = rd_addr_q + pps_pkg::ADDR_STEP;
        unique case (w_op)
            pps_pkg::OP_END_LOOP: begin
                if (loop_top > pps_pkg::LOOP_LAST_PASS) begin
                    nxt_addr = w_data[pps_pkg::AW-1:0];
                end
            end
            pps_pkg::OP_SUBROUTINE_CALL: nxt_addr = w_data[pps_pkg::AW-1:0];
            pps_pkg::OP_RETURN: nxt_addr = ret_addr_q[csp_q - pps_pkg::SP_STEP];
            pps_pkg::OP_JUMP: nxt_addr = w_data[pps_pkg::AW-1:0];
            default: nxt_addr = rd_addr_q + pps_pkg::ADDR_STEP;
        endcase
    end

    // memory port: sequencer reads while running, loader writes while idle
    assign seq_addr = start_req ? pps_pkg::PROG_START_ADDR : nxt_addr;
    assign mem_re = (start_req && !busy) || adv;
    assign mem_we = commit;
    assign mem_addr = mem_re ? seq_addr : prog_addr_q;
    assign mem_wdata = {pwdata[pps_pkg::PAT_W-1:0], prog_data_q, prog_op_q, prog_dly_q};

    pps_prog_mem u_mem (
        .pclk(pclk),
        .we(mem_we),
        .re(mem_re),
        .addr(mem_addr),
        .wdata(mem_wdata),
        .rdata(mem_rdata)
    );

    // register read mux
    always_comb begin
        rd_val = '0;
        unique case (paddr)
            pps_pkg::REG_STATUS: begin
                rd_val[pps_pkg::ST_RUN_BIT] = running;
                rd_val[pps_pkg::ST_STOP_BIT] = stopped;
                rd_val[pps_pkg::ST_WAIT_BIT] = waiting;
                rd_val[pps_pkg::ST_PC_LSB +: pps_pkg::AW] = pc_q;
            end
            pps_pkg::REG_PROG_ADDR: rd_val[pps_pkg::AW-1:0] = prog_addr_q;
            pps_pkg::REG_PROG_DELAY: rd_val = prog_dly_q;
            pps_pkg::REG_PROG_CTRL: begin
                rd_val[pps_pkg::PCTRL_OP_LSB +: pps_pkg::OP_W] = prog_op_q;
                rd_val[pps_pkg::PCTRL_DATA_LSB +: pps_pkg::DATA_W] = prog_data_q;
            end
            default: rd_val = '0;
        endcase
    end

    // apb slave: one wait state so every bus output leaves a flip-flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else if (psel && penable && !pready) begin
            pready <= 1'b1;
            pslverr <= !reg_hit(paddr);
            prdata <= rd_val;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // program staging registers; the pattern write commits a whole word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prog_addr_q <= '0;
            prog_dly_q <= '0;
            prog_op_q <= '0;
            prog_data_q <= '0;
        end else begin
            if (wr_fire && (paddr == pps_pkg::REG_PROG_ADDR)) begin
                prog_addr_q <= pwdata[pps_pkg::AW-1:0];
            end else if (commit) begin
                prog_addr_q <= prog_addr_q + pps_pkg::ADDR_STEP; // streams consecutive words
            end
            if (wr_fire && (paddr == pps_pkg::REG_PROG_DELAY)) begin
                prog_dly_q <= pwdata;
            end
            if (wr_fire && (paddr == pps_pkg::REG_PROG_CTRL)) begin
                prog_op_q <= pwdata[pps_pkg::PCTRL_OP_LSB +: pps_pkg::OP_W];
                prog_data_q <= pwdata[pps_pkg::PCTRL_DATA_LSB +: pps_pkg::DATA_W];
            end
        end
    end

    // loop counters and return addresses; pointers wrap when depth is exceeded
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lsp_q <= '0;
            csp_q <= '0;
            for (int i = 0; i < pps_pkg::STK_DEPTH; i++) begin
                loop_cnt_q[i] <= '0;
                ret_addr_q[i] <= '0;
            end
        end else if (start_req && !busy) begin
            lsp_q <= '0;
            csp_q <= '0;
        end else if (adv) begin
            unique case (w_op)
                pps_pkg::OP_LOOP: begin
                    loop_cnt_q[lsp_q] <= w_data;
                    lsp_q <= lsp_q + pps_pkg::SP_STEP;
                end
                pps_pkg::OP_END_LOOP: begin
                    if (loop_top > pps_pkg::LOOP_LAST_PASS) begin
                        loop_cnt_q[lsp_q - pps_pkg::SP_STEP] <= loop_top - pps_pkg::LOOP_DEC;
                    end else begin
                        lsp_q <= lsp_q - pps_pkg::SP_STEP;
                    end
                end
                pps_pkg::OP_SUBROUTINE_CALL: begin
                    ret_addr_q[csp_q] <= rd_addr_q + pps_pkg::ADDR_STEP;
                    csp_q <= csp_q + pps_pkg::SP_STEP;
                end
                pps_pkg::OP_RETURN: csp_q <= csp_q - pps_pkg::SP_STEP;
                default: lsp_q <= lsp_q;
            endcase
        end
    end

    // sequencer state, duration counter, program counter and output pattern
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= pps_pkg::PPS_IDLE;
            cnt_q <= '0;
            rd_addr_q <= '0;
            pc_q <= '0;
            dly_q <= '0;
            out_pattern <= '0;
        end else if (halt_req && busy) begin
            state_q <= pps_pkg::PPS_STOPPED;
        end else if (start_req && !busy) begin
            state_q <= pps_pkg::PPS_PRIME;
            rd_addr_q <= pps_pkg::PROG_START_ADDR;
        end else if (adv) begin
            pc_q <= rd_addr_q;
            dly_q <= w_dly;
            if (w_op == pps_pkg::OP_STOP) begin
                // outputs keep the previous instruction's pattern
                state_q <= pps_pkg::PPS_STOPPED;
            end else begin
                out_pattern <= w_pat;
                rd_addr_q <= nxt_addr;
                cnt_q <= dur_m1(w_op, w_dly, w_data);
                if (w_op == pps_pkg::OP_WAIT) begin
                    state_q <= pps_pkg::PPS_WAIT;
                end else begin
                    state_q <= pps_pkg::PPS_EXEC;
                end
            end
        end else if (state_q == pps_pkg::PPS_WAIT) begin
            if (!trig_n) begin
                // exit latency is the wait's own delay plus a fixed extra
                cnt_q <= {{(pps_pkg::CNT_W-pps_pkg::DLY_W){1'b0}}, dly_q} +
                         pps_pkg::WAIT_EXTRA_CYC - pps_pkg::CNT_ONE;
                state_q <= pps_pkg::PPS_EXEC;
            end
        end else if (state_q == pps_pkg::PPS_EXEC) begin
            cnt_q <= cnt_q - pps_pkg::CNT_ONE;
        end
    end

    // status pins follow the next state so they stay aligned with state_q
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            running <= 1'b0;
            stopped <= 1'b0;
            waiting <= 1'b0;
        end else if (halt_req && busy) begin
            running <= 1'b0;
            stopped <= 1'b1;
            waiting <= 1'b0;
        end else if (start_req && !busy) begin
            running <= 1'b1;
            stopped <= 1'b0;
            waiting <= 1'b0;
        end else if (adv) begin
            running <= (w_op != pps_pkg::OP_STOP);
            stopped <= (w_op == pps_pkg::OP_STOP);
            waiting <= (w_op == pps_pkg::OP_WAIT);
        end else if ((state_q == pps_pkg::PPS_WAIT) && !trig_n) begin
            waiting <= 1'b0;
        end
    end
    // a wait at address zero still works here, though loaders must not rely on it
    // (the restriction and the advice for a leading continue stay with the program)
endmodule : pps_sequencer

/* File: verif/pps_trig_src.sv */
// partner model: external trigger source facing the sequencer
`timescale 1ns/1ps
module pps_trig_src #(
    parameter int HOLD = 20 // cycles of waiting before the trigger fires, minus one
) (
    input wire logic pclk, // clock
    input wire logic presetn, // reset, active low
    input wire logic waiting, // sequencer suspended
    output logic trig_n // trigger, active low
);
    int cnt_q = 0;
    logic pull_q = 1'b0;

    // fire late in a wait so an early exit shows up as a wrong duration
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 0;
            pull_q <= 1'b0;
        end else if (waiting !== 1'b1) begin
            cnt_q <= 0;
            pull_q <= 1'b0; // line idles high outside a wait
        end else if (cnt_q == HOLD) begin
            pull_q <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 1;
        end
    end
    assign trig_n = ~pull_q;
endmodule : pps_trig_src

/* File: verif/pps_seq_monitor.sv */
// assertions on the ports of the pulse program sequencer
`timescale 1ns/1ps
module pps_seq_monitor (
    input wire logic pclk, // clock
    input wire logic presetn, // reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [31:0] prdata, // apb read data
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire logic trig_n, // trigger, active low
    input wire logic [23:0] out_pattern, // output bits
    input wire logic running, // executing
    input wire logic stopped, // halted
    input wire logic waiting // suspended
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // halt flags are exclusive, and a stop keeps the previous pattern
    a_flags_exclusive: assert property (!(running && stopped))
        else $error("running and stopped both high");
    a_stop_keeps: assert property ($rose(stopped) |-> $stable(out_pattern) && !running)
        else $error("stop changed pattern or kept running");
    // five cycles minimum: a new pattern stands at least four more edges
    a_min_duration: assert property ($changed(out_pattern) |=> $stable(out_pattern)[*4])
        else $error("pattern held under five cycles");
    a_wait_suspends: assert property (waiting && trig_n |=> $stable(out_pattern))
        else $error("wait left without trigger");
    a_wait_exit_late: assert property (waiting && $fell(trig_n) |=> $stable(out_pattern)[*8])
        else $error("wait exit too early");
    // access lasts exactly two cycles after setup
    a_apb_answer: assert property (psel && !penable |-> ##1 !pready ##1 pready)
        else $error("apb answer timing wrong");
    a_unmapped_err: assert property (psel && penable && pready && paddr > 12'h014 |-> pslverr)
        else $error("unmapped access without error");
    a_err_reads_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");

    c_stop: cover property ($rose(stopped));
    c_trigger: cover property (waiting && $fell(trig_n));
    c_error: cover property (pready && pslverr);
endmodule : pps_seq_monitor

/* File: verif/pps_sequencer_bench.sv */
// self-checking bench: loads a program over apb, runs it, times each pattern
`timescale 1ns/1ps
module pps_sequencer_bench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic trig_n;
    logic [23:0] out_pattern;
    logic running;
    logic stopped;
    logic waiting;
    logic [31:0] seed = 32'h4e65c5c3;
    int miscompares = 0;
    int num_checks = 0;
    logic [23:0] exp_pat[$];
    int exp_dur[$];
    logic [23:0] pat_m[32];
    logic [3:0] op_m[32];
    logic [19:0] dat_m[32];
    logic [31:0] dly_m[32];
    // program in load order; -1 asks for a random don't-care value
    int p_adr[12] = '{0, 1, 2, 3, 4, 5, 8, 9, 10, 11, 20, 21};
    int p_op[12] = '{0, 2, 0, 3, 4, 6, 7, 9, 8, 1, 0, 5};
    int p_dat[12] = '{-1, 2, -1, 2, 20, 8, 3, -1, -1, -1, -1, -1};
    int p_dly[12] = '{5, 6, 7, 6, 5, 5, 6, 6, 6, -1, 5, 6};
    int p_ord[13] = '{0, 1, 2, 3, 2, 3, 4, 20, 21, 5, 8, 9, 10};

    always #10 pclk = ~pclk;

    pps_sequencer dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .trig_n(trig_n), .out_pattern(out_pattern), .running(running), .stopped(stopped),
        .waiting(waiting)
    );
    pps_trig_src #(.HOLD(20)) trig_u (
        .pclk(pclk), .presetn(presetn), .waiting(waiting), .trig_n(trig_n)
    );

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    task automatic chk_pat(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected pattern at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk_pat

    task automatic chk_dur(input int got, input int exp);
        num_checks++;
        if (got != exp) begin
            miscompares++;
            $display("unexpected duration at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk_dur

    task automatic chk_reg(input logic [32:0] got, input logic [32:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected register at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk_reg

    // one apb transfer; returns {pslverr, prdata} taken at the ready edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [32:0] r);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // wait for the slave; only the bench watchdog ends a hung transfer
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = {pslverr, prdata};
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // one instruction word: address, delay, opcode with data, then the committing pattern
    task automatic ld(input int a);
        logic [32:0] r;
        apb(1'b1, pps_pkg::REG_PROG_ADDR, 32'(a), r);
        apb(1'b1, pps_pkg::REG_PROG_DELAY, dly_m[a], r);
        apb(1'b1, pps_pkg::REG_PROG_CTRL, {8'h00, dat_m[a], op_m[a]}, r);
        apb(1'b1, pps_pkg::REG_PROG_PATTERN, {8'h00, pat_m[a]}, r);
    endtask : ld

    task automatic print_verdict();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict

    // main sequence: load, note expected order, start, then inspect registers
    initial begin
        logic [32:0] r;
        logic [31:0] v;
        int a;
        int n;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            a = p_adr[i];
            v = xs();
            pat_m[a] = {v[15:0], 8'(a)};
            op_m[a] = (p_op[i] == 9) ? 4'(9 + v[31:16] % 7) : 4'(p_op[i]);
            dat_m[a] = (p_dat[i] < 0) ? v[31:12] : 20'(p_dat[i]);
            dly_m[a] = (p_dly[i] < 0) ? {24'h0, v[23:16]} : 32'(p_dly[i]);
            ld(a);
        end
        foreach (p_ord[k]) begin
            a = p_ord[k];
            exp_pat.push_back(pat_m[a]);
            if (op_m[a] == 4'h7) exp_dur.push_back(int'(dly_m[a] * dat_m[a]));
            else if (op_m[a] == 4'h8) exp_dur.push_back(-int'(dly_m[a]) - 7);
            else exp_dur.push_back(int'(dly_m[a]));
        end
        exp_pat.push_back(pat_m[10]); // stop keeps the wait's pattern
        exp_dur.push_back(0);
        apb(1'b1, pps_pkg::REG_CTRL, 32'h1, r);
        n = 0;
        while (stopped !== 1'b1 && n < 3000) begin
            @(posedge pclk);
            n++;
        end
        repeat (4) @(posedge pclk);
        chk_dur(exp_pat.size(), 0);
        apb(1'b0, pps_pkg::REG_STATUS, 32'h0, r);
        chk_reg({r[32], 29'h0, r[2:0]}, 33'h000000002);
        apb(1'b0, pps_pkg::REG_PROG_ADDR, 32'h0, r);
        chk_reg(r, 33'h000000016);
        apb(1'b0, 12'hffc, 32'h0, r);
        chk_reg(r, 33'h100000000);
        apb(1'b0, pps_pkg::REG_PROG_CTRL, 32'h0, r);
        chk_reg(r, {9'h000, dat_m[21], op_m[21]});
        // restart, then halt inside the first instruction; the pattern must stay put
        exp_pat.push_back(pat_m[0]);
        exp_dur.push_back(0);
        exp_pat.push_back(pat_m[0]);
        exp_dur.push_back(0);
        apb(1'b1, pps_pkg::REG_CTRL, 32'h1, r);
        apb(1'b1, pps_pkg::REG_CTRL, 32'h2, r);
        repeat (4) @(posedge pclk);
        chk_dur(exp_pat.size(), 0);
        apb(1'b0, pps_pkg::REG_STATUS, 32'h0, r);
        chk_reg({r[32], 29'h0, r[2:0]}, 33'h000000002);
        print_verdict();
    end

    // watcher: every new pattern, or the stop, retires the oldest note
    initial begin
        logic [23:0] pp;
        logic ps;
        int cyc;
        int last;
        int tk;
        int cd;
        pp = 24'h0;
        ps = 1'b0;
        cyc = 0;
        last = 0;
        tk = -1;
        cd = 0;
        wait (presetn === 1'b1);
        forever begin
            @(posedge pclk);
            #1;
            cyc++;
            if (trig_n === 1'b0 && tk < 0) tk = cyc;
            if (out_pattern !== pp || (stopped === 1'b1 && ps !== 1'b1)) begin
                if (cd > 0) chk_dur(cyc - last, cd);
                if (cd < 0) chk_dur(cyc - tk, -cd);
                if (exp_pat.size() == 0) begin
                    miscompares++;
                    $display("unexpected change at %0t: got %h exp %h", $time, out_pattern, pp);
                end else begin
                    chk_pat(out_pattern, exp_pat.pop_front());
                    cd = exp_dur.pop_front();
                end
                last = cyc;
            end
            pp = out_pattern;
            ps = stopped;
        end
    end

    // loading and running take under two thousand cycles; allow ample slack
    initial begin
        repeat (6000) @(posedge pclk);
        miscompares++;
        $display("unexpected hang at %0t: got %h exp %h", $time, 1'b0, 1'b1);
        print_verdict();
    end
endmodule : pps_sequencer_bench

bind pps_sequencer pps_seq_monitor mon_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trig_n(trig_n), .out_pattern(out_pattern), .running(running), .stopped(stopped),
    .waiting(waiting)
);
